//--- include/imcs_pkg.sv
// constants and types for the i2c master command sequencer
package imcs_pkg;
  localparam int          ADDR_W     = 8;
  localparam logic [7:0]  CMD_OFS    = 8'h00;
  localparam logic [7:0]  STAT_OFS   = 8'h04;
  localparam logic [31:0] CMD_RST    = 32'h0;
  localparam int          CMD_W      = 26;
  localparam int          DIR_BIT    = 0;
  localparam int          ALO_LSB    = 1;
  localparam int          AHI_LSB    = 8;
  localparam int          SB_BIT     = 11;
  localparam int          AM_LSB     = 12;
  localparam int          STOP_BIT   = 14;
  localparam int          LEN_LSB    = 15;
  localparam int          LEN_W      = 11;
  localparam int          ST_BUSY    = 0;
  localparam int          ST_ERR     = 1;
  localparam int          ST_HOLD    = 2;
  localparam int          ST_ACK     = 3;
  localparam int          ST_CNT_LSB = 8;
  localparam logic [1:0]  AM_GC      = 2'h0;
  localparam logic [1:0]  AM_7       = 2'h1;
  localparam logic [1:0]  AM_10      = 2'h2;
  localparam logic [7:0]  START_BYTE = 8'h01;
  localparam logic [4:0]  TEN_PFX    = 5'h1e;
  localparam int          CLK_HZ     = 20000000;
  localparam int          QTR_NS     = 2500;
  localparam int          QTR_CYC    = (QTR_NS * (CLK_HZ / 1000000)) / 1000;
  typedef enum logic [5:0] {
    S_IDLE  = 6'h01,
    S_START = 6'h02,
    S_LOAD  = 6'h04,
    S_BIT   = 6'h08,
    S_RXH   = 6'h10,
    S_STOP  = 6'h20
  } imcs_state_e;
  typedef enum logic [2:0] {
    PH_SB    = 3'h0,
    PH_ADDR1 = 3'h1,
    PH_ADDR2 = 3'h2,
    PH_ADDR3 = 3'h3,
    PH_DATA  = 3'h4
  } imcs_phase_e;
endpackage

//--- design/imcs_top.sv
// i2c master command sequencer: command register, byte sequencer and bit engine
//
// Decided for this implementation: the address map and strobed register access.
`timescale 1ns/1ns
module imcs_top #(
  parameter int QTR_CYC = imcs_pkg::QTR_CYC
) (
  input  wire logic                        ref_clk_i,
  input  wire logic                        nrst_i,
  input  wire logic [imcs_pkg::ADDR_W-1:0] reg_addr_i,
  input  wire logic [31:0]                 reg_wdata_i,
  input  wire logic                        reg_wr_i,
  input  wire logic                        reg_rd_i,
  output logic      [31:0]                 reg_rdata_o,
  input  wire logic [7:0]                  tx_data_i,
  input  wire logic                        tx_valid_i,
  output logic                             tx_ready_o,
  output logic      [7:0]                  rx_data_o,
  output logic                             rx_valid_o,
  input  wire logic                        rx_ready_i,
  input  wire logic                        scl_i,
  output logic                             scl_o,
  output logic                             scl_oe_o,
  input  wire logic                        sda_i,
  output logic                             sda_o,
  output logic                             sda_oe_o
);
  import imcs_pkg::*;
  localparam int DIV_W = $clog2(QTR_CYC + 1);

  logic [1:0]       rst_sync_r;
  logic             rst_n;
  logic             scl_meta_r, scl_s_r, sda_meta_r, sda_s_r;
  logic [DIV_W-1:0] div_r;
  imcs_state_e      state_r, state_nxt;
  imcs_phase_e      phase_r, phase_nxt;
  logic [CMD_W-1:0] cmd_r;
  logic [LEN_W-1:0] count_r, count_nxt;
  logic [7:0]       shift_r, shift_nxt;
  logic [3:0]       bit_r, bit_nxt;
  logic [1:0]       q_r, q_nxt;
  logic             scl_low_r, scl_low_nxt, sda_low_r, sda_low_nxt;
  logic             pend_r, pend_nxt, hold_r, hold_nxt, err_r, err_nxt, err_set;
  logic             ack_r, ack_nxt;
  logic [31:0]      rdata_r;

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) rst_sync_r <= 2'b00;
    else rst_sync_r <= {rst_sync_r[0], 1'b1};
  end
  assign rst_n = rst_sync_r[1];

  // bus pins are asynchronous to ref_clk_i
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      {scl_meta_r, scl_s_r, sda_meta_r, sda_s_r} <= 4'hf;
    end else begin
      scl_meta_r <= scl_i;
      scl_s_r    <= scl_meta_r;
      sda_meta_r <= sda_i;
      sda_s_r    <= sda_meta_r;
    end
  end

  wire tick_w = (div_r == '0);
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) div_r <= '0;
    else div_r <= tick_w ? DIV_W'(QTR_CYC - 1) : div_r - 1'b1;
  end

  // command fields
  wire             dir_w  = cmd_r[DIR_BIT];
  wire [6:0]       alo_w  = cmd_r[ALO_LSB +: 7];
  wire [2:0]       ahi_w  = cmd_r[AHI_LSB +: 3];
  wire             sb_w   = cmd_r[SB_BIT];
  wire [1:0]       am_w   = cmd_r[AM_LSB +: 2];
  wire             stop_w = cmd_r[STOP_BIT];
  wire [LEN_W-1:0] len_w  = cmd_r[LEN_LSB +: LEN_W];
  wire             is_rd_w = dir_w && (am_w != AM_GC);
  wire             is_10_w = (am_w == AM_10);
  wire             rx_mode_w = is_rd_w && (phase_r == PH_DATA);
  wire             busy_w = pend_r || (state_r != S_IDLE);

  // address byte per phase; general call ignores direction and address
  wire [7:0] ten_hi_w = {TEN_PFX, ahi_w[2:1], 1'b0};
  wire [7:0] a1_w = (am_w == AM_GC) ? 8'h00 : is_10_w ? ten_hi_w : {alo_w, dir_w};
  wire [7:0] addr_byte_w = (phase_r == PH_SB)    ? START_BYTE :
                           (phase_r == PH_ADDR1) ? a1_w :
                           (phase_r == PH_ADDR2) ? {ahi_w[0], alo_w} :
                           {TEN_PFX, ahi_w[2:1], 1'b1};

  // register decode
  wire wr_cmd_w   = reg_wr_i && (reg_addr_i == CMD_OFS);
  wire wr_stat_w  = reg_wr_i && (reg_addr_i == STAT_OFS);
  wire cmd_take_w = wr_cmd_w && !busy_w;
  wire err_clr_w  = (wr_stat_w && reg_wdata_i[ST_ERR]) || cmd_take_w;
  wire go_w = (state_r == S_IDLE) && pend_r && (is_rd_w || len_w == '0 || tx_valid_i);
  wire last_rx_w = (count_r == LEN_W'(1));
  wire out_bit_w = (bit_r < 4'd8) ? (rx_mode_w || shift_r[7]) : (!rx_mode_w || last_rx_w);
  wire [31:0] stat_w = {13'h0, count_r, 4'h0, ack_r, hold_r, err_r, busy_w};
  wire [31:0] rd_mux_w = (reg_addr_i == CMD_OFS)  ? {{(32-CMD_W){1'b0}}, cmd_r} :
                         (reg_addr_i == STAT_OFS) ? stat_w : 32'h0;

  assign tx_ready_o  = (state_r == S_LOAD) && (phase_r == PH_DATA) && !is_rd_w && tx_valid_i;
  assign rx_valid_o  = (state_r == S_RXH);
  assign rx_data_o   = shift_r;
  assign scl_o       = 1'b0;
  assign sda_o       = 1'b0;
  assign scl_oe_o    = scl_low_r;
  assign sda_oe_o    = sda_low_r;
  assign reg_rdata_o = rdata_r;

  always_comb begin
    state_nxt   = state_r;
    phase_nxt   = phase_r;
    count_nxt   = count_r;
    shift_nxt   = shift_r;
    bit_nxt     = bit_r;
    q_nxt       = q_r;
    scl_low_nxt = scl_low_r;
    sda_low_nxt = sda_low_r;
    pend_nxt    = pend_r || cmd_take_w;
    hold_nxt    = hold_r;
    ack_nxt     = ack_r;
    err_set     = 1'b0;
    case (state_r)
      S_IDLE: begin
        if (go_w) begin
          state_nxt = S_START;
          q_nxt     = 2'd0;
          pend_nxt  = 1'b0;
          count_nxt = len_w;
          phase_nxt = sb_w ? PH_SB : PH_ADDR1;
        end
      end
      S_START: if (tick_w) begin
        case (q_r)
          2'd0: begin sda_low_nxt = 1'b0; q_nxt = 2'd1; end
          2'd1: begin scl_low_nxt = 1'b0; q_nxt = 2'd2; end
          2'd2: if (scl_s_r && sda_s_r) begin
            sda_low_nxt = 1'b1;
            q_nxt       = 2'd3;
          end
          default: begin
            scl_low_nxt = 1'b1;
            q_nxt       = 2'd0;
            hold_nxt    = 1'b0;
            state_nxt   = S_LOAD;
          end
        endcase
      end
      S_LOAD: begin
        // a write byte waits here with the clock held low
        if (phase_r != PH_DATA || is_rd_w || tx_valid_i) begin
          shift_nxt = (phase_r == PH_DATA) ? tx_data_i : addr_byte_w;
          bit_nxt   = 4'd0;
          q_nxt     = 2'd0;
          state_nxt = S_BIT;
        end
      end
      S_BIT: if (tick_w) begin
        case (q_r)
          2'd0: begin sda_low_nxt = !out_bit_w; q_nxt = 2'd1; end
          2'd1: begin scl_low_nxt = 1'b0; q_nxt = 2'd2; end
          2'd2: if (scl_s_r) begin
            // a slow target stretches here
            if (bit_r < 4'd8) shift_nxt = {shift_r[6:0], sda_s_r};
            else ack_nxt = sda_s_r;
            q_nxt = 2'd3;
          end
          default: begin
            scl_low_nxt = 1'b1;
            q_nxt       = 2'd0;
            if (bit_r == 4'd7 && rx_mode_w) begin
              bit_nxt   = 4'd8;
              state_nxt = S_RXH;
            end else if (bit_r != 4'd8) begin
              bit_nxt = bit_r + 4'd1;
            end else if (ack_r && !rx_mode_w && phase_r != PH_SB) begin
              err_set   = 1'b1;
              sda_low_nxt = 1'b1;
              state_nxt = S_STOP;
            end else begin
              state_nxt = S_LOAD;
              case (phase_r)
                PH_SB:    begin phase_nxt = PH_ADDR1; state_nxt = S_START; end
                PH_ADDR1: if (is_10_w) phase_nxt = PH_ADDR2;
                          else phase_nxt = PH_DATA;
                PH_ADDR2: if (is_rd_w) begin phase_nxt = PH_ADDR3; state_nxt = S_START; end
                          else phase_nxt = PH_DATA;
                PH_ADDR3: phase_nxt = PH_DATA;
                default:  count_nxt = count_r - LEN_W'(1);
              endcase
              if ((phase_r == PH_DATA && last_rx_w) ||
                  (phase_nxt == PH_DATA && phase_r != PH_DATA && count_r == '0)) begin
                if (stop_w) begin
                  sda_low_nxt = 1'b1;
                  state_nxt   = S_STOP;
                end else begin
                  hold_nxt  = 1'b1;
                  state_nxt = S_IDLE;
                end
              end
            end
          end
        endcase
      end
      S_RXH: begin
        if (rx_ready_i) state_nxt = S_BIT;
      end
      S_STOP: if (tick_w) begin
        case (q_r)
          2'd0: begin sda_low_nxt = 1'b1; q_nxt = 2'd1; end
          2'd1: begin scl_low_nxt = 1'b0; q_nxt = 2'd2; end
          2'd2: if (scl_s_r) q_nxt = 2'd3;
          default: begin
            sda_low_nxt = 1'b0;
            q_nxt       = 2'd0;
            hold_nxt    = 1'b0;
            state_nxt   = S_IDLE;
          end
        endcase
      end
      default: state_nxt = S_IDLE;
    endcase
    err_nxt = err_set || (err_r && !err_clr_w);
  end

  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= S_IDLE;
      phase_r <= PH_ADDR1;
      cmd_r   <= CMD_RST[CMD_W-1:0];
      count_r <= '0;
      shift_r <= 8'h00;
      bit_r   <= 4'h0;
      q_r     <= 2'h0;
      {scl_low_r, sda_low_r, pend_r, hold_r, err_r, ack_r} <= 6'h00;
      rdata_r <= 32'h0;
    end else begin
      state_r <= state_nxt;
      phase_r <= phase_nxt;
      if (cmd_take_w) cmd_r <= reg_wdata_i[CMD_W-1:0];
      count_r <= count_nxt;
      shift_r <= shift_nxt;
      bit_r   <= bit_nxt;
      q_r     <= q_nxt;
      {scl_low_r, sda_low_r, pend_r, hold_r, err_r, ack_r} <=
        {scl_low_nxt, sda_low_nxt, pend_nxt, hold_nxt, err_nxt, ack_nxt};
      rdata_r <= reg_rd_i ? rd_mux_w : 32'h0;
    end
  end

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n);

  property p_dir;
    rx_valid_o |-> dir_w && am_w != AM_GC;
  endproperty
  a_dir: assert property (p_dir) else $error("read data during a write");
  property p_addr7;
    (state_r == S_LOAD && phase_r == PH_ADDR1 && am_w == AM_7) ##1 state_r == S_BIT |-> shift_r == {alo_w, dir_w};
  endproperty
  a_addr7: assert property (p_addr7) else $error("wrong 7-bit address byte");
  property p_addr10;
    (state_r == S_LOAD && phase_r == PH_ADDR2) ##1 state_r == S_BIT |-> shift_r == {ahi_w[0], alo_w};
  endproperty
  a_addr10: assert property (p_addr10) else $error("wrong 10-bit low byte");
  property p_sb;
    (state_r == S_IDLE && go_w) |=> phase_r == (sb_w ? PH_SB : PH_ADDR1);
  endproperty
  a_sb: assert property (p_sb) else $error("start byte phase wrong");
  property p_gc;
    (state_r == S_LOAD && phase_r == PH_ADDR1 && am_w == AM_GC) ##1 state_r == S_BIT |-> shift_r == 8'h00;
  endproperty
  a_gc: assert property (p_gc) else $error("general call byte wrong");
  property p_stop;
    (state_r == S_BIT && state_nxt == S_STOP) |-> stop_w || err_set;
  endproperty
  a_stop: assert property (p_stop) else $error("stop without request");
  property p_hold;
    $rose(hold_r) |-> !stop_w && scl_oe_o && state_r == S_IDLE;
  endproperty
  a_hold: assert property (p_hold) else $error("bus not held for repeated start");
  property p_txcnt;
    tx_ready_o |-> count_r != '0 && !is_rd_w;
  endproperty
  a_txcnt: assert property (p_txcnt) else $error("byte taken beyond length");
  property p_nack;
    (state_r == S_BIT && bit_r == 4'd8 && rx_mode_w && q_r != 2'd0) |-> sda_oe_o == !last_rx_w;
  endproperty
  a_nack: assert property (p_nack) else $error("ack level wrong on read");
  property p_stall;
    (state_r == S_RXH && !rx_ready_i) |=> scl_oe_o && state_r == S_RXH;
  endproperty
  a_stall: assert property (p_stall) else $error("clock not held during stall");
  property p_txwait;
    (state_r == S_IDLE && pend_r && !is_rd_w && len_w != '0 && !tx_valid_i) |=> state_r != S_START;
  endproperty
  a_txwait: assert property (p_txwait) else $error("write started without data");
  c_gc:    cover property (state_r == S_LOAD && phase_r == PH_ADDR1 && am_w == AM_GC);
  c_rd10:  cover property (phase_r == PH_ADDR3 && state_r == S_BIT);
  c_stall: cover property (state_r == S_RXH && !rx_ready_i ##1 rx_ready_i);
  c_hold:  cover property ($rose(hold_r));
endmodule // imcs_top

//--- bench/imcs_tgt.sv
// behavioural i2c target: logs bytes, acks all but the start byte, serves read data
`timescale 1ns/1ns
module imcs_tgt (
  input  wire logic clk_i,
  input  wire logic scl_i,
  input  wire logic sda_i,
  output logic      sda_oe_o
);
  logic [7:0] sh, rb;
  logic [7:0] log_q [0:15];
  logic       ps, pd, rd, first;
  int         bitn, n, nstop, nack, nnak, rdn;
  initial begin
    {ps, pd, sda_oe_o, rd, first} = 5'h18;
    {bitn, n, nstop, nack, nnak, rdn} = '0;
  end
  // sampled on the falling system edge, away from the master's launch edge
  always @(negedge clk_i) begin
    if (ps && scl_i && pd && !sda_i) begin
      bitn = 0;
      first = 1;
      rd = 0;
      rdn = 0;
    end else if (ps && scl_i && !pd && sda_i) begin
      nstop++;
    end else if (!ps && scl_i) begin
      if (bitn < 8) begin
        sh = {sh[6:0], sda_i};
        bitn++;
      end else begin
        // only the master's answer bits count, not our own address ack
        if (rd && !first && !sda_oe_o && sda_i) nnak++;
        if (rd && !first && !sda_oe_o && !sda_i) nack++;
        if (rd && !first && !sda_oe_o && sda_i) rd = 0;
        bitn = 0;
      end
    end else if (ps && !scl_i) begin
      sda_oe_o = 0;
      if (bitn == 8 && !(rd && !first)) begin
        log_q[n] = sh;
        n++;
        // nobody answers the start byte
        sda_oe_o = sh != 8'h01;
        if (first) rd = sh[0] && sh != 8'h01;
        first = 0;
      end else if (rd && !first && bitn < 8) begin
        if (bitn == 0) rb = 8'ha5 + rdn[7:0];
        if (bitn == 0) rdn++;
        sda_oe_o = !rb[7-bitn];
      end
    end
    ps = scl_i;
    pd = sda_i;
  end
endmodule // imcs_tgt

//--- bench/testbench.sv
// self-checking bench for the i2c master command sequencer
`timescale 1ns/1ns
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin err_count++; \
  $display("[ERR] %0t got %h exp %h", $time, a, b); end end
module testbench;
  import imcs_pkg::*;
  logic        ref_clk_i = 0, nrst_i = 0, wr = 0, rd = 0, txv = 0, rxr = 0, txen = 1;
  logic [7:0]  addr = 8'h00, txd = 8'h00, rxd;
  logic [31:0] wdata = 32'h0, rdata, st;
  logic        txr, rxv, scl_o, scl_oe, sda_o, sda_oe, tgt_oe;
  int          err_count = 0, total_checks = 0, wait_n, stall = 0, tn = 0;
  logic [7:0]  txq [$], rxq [$], exp [$];
  // open drain wires with pull-ups
  wire scl = scl_oe ? scl_o : 1'b1;
  wire sda = (sda_oe ? sda_o : 1'b1) & ~tgt_oe;
  always #25 ref_clk_i = ~ref_clk_i;
  imcs_top #(.QTR_CYC(2)) u_imcs_top (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .reg_addr_i(addr),
    .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .tx_data_i(txd),
    .tx_valid_i(txv), .tx_ready_o(txr), .rx_data_o(rxd), .rx_valid_o(rxv), .rx_ready_i(rxr),
    .scl_i(scl), .scl_o(scl_o), .scl_oe_o(scl_oe), .sda_i(sda), .sda_o(sda_o), .sda_oe_o(sda_oe));
  imcs_tgt u_imcs_tgt (.clk_i(ref_clk_i), .scl_i(scl), .sda_i(sda), .sda_oe_o(tgt_oe));
  always @(posedge ref_clk_i) begin
    if (txr && txv) void'(txq.pop_front());
    txv <= txen && txq.size() > 0;
    txd <= txq.size() > 0 ? txq[0] : 8'h00;
    if (rxv && rxr) rxq.push_back(rxd);
    // slow receive side, so the stall is visible
    stall <= (rxv && !rxr) ? stall + 1 : 0;
    rxr <= rxv && !rxr && stall == 6;
    if (stall == 3) `CHK(scl_oe, 1'b1)
  end
  task wreg(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk_i);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge ref_clk_i);
    wr <= 1'b0;
  endtask
  task rreg(input logic [7:0] a, output logic [31:0] d);
    @(posedge ref_clk_i);
    addr <= a;
    rd <= 1'b1;
    @(posedge ref_clk_i);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  function logic [31:0] mk(input logic dir, input logic [9:0] a, input logic sb, input logic [1:0] am,
                           input logic stp, input logic [10:0] len);
    mk = 32'h0;
    mk[DIR_BIT] = dir;
    mk[ALO_LSB +: 7] = a[6:0];
    mk[AHI_LSB +: 3] = a[9:7];
    mk[SB_BIT] = sb;
    mk[AM_LSB +: 2] = am;
    mk[STOP_BIT] = stp;
    mk[LEN_LSB +: LEN_W] = len;
  endfunction
  task go(input logic [31:0] c, input int ntx);
    u_imcs_tgt.n = 0;
    rxq.delete();
    for (int i = 0; i < ntx; i++) txq.push_back(8'h30 + i[7:0]);
    wreg(CMD_OFS, c);
    if (!txen) begin
      repeat (40) @(posedge ref_clk_i);
      `CHK(scl_oe | sda_oe, 1'b0)
      txen <= 1'b1;
    end
    wait_n = 0;
    st = 32'h1;
    while (st[ST_BUSY] === 1'b1 && wait_n < 3000) begin
      rreg(STAT_OFS, st);
      wait_n++;
    end
  endtask
  task cmp;
    `CHK(u_imcs_tgt.n, exp.size())
    foreach (exp[i]) `CHK(u_imcs_tgt.log_q[i], exp[i])
    `CHK(st[ST_ERR], 1'b0)
    tn++;
    $display("test %0d done", tn);
  endtask
  task rxchk(input int k);
    `CHK(rxq.size(), k)
    for (int i = 0; i < k; i++) `CHK(rxq[i], 8'ha5 + i[7:0])
  endtask
  task summarize;
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    #2000000;
    err_count++;
    summarize();
  end
  initial begin
    repeat (5) @(posedge ref_clk_i);
    nrst_i <= 1'b1;
    repeat (3) @(posedge ref_clk_i);
    rreg(CMD_OFS, st);
    `CHK(st, CMD_RST)
    rreg(8'h08, st);
    `CHK(st, 32'h0)
    txen <= 1'b0;
    exp = '{8'h54, 8'h30, 8'h31};
    go(mk(0, 10'h02a, 0, AM_7, 1, 2), 2);
    cmp();
    `CHK(txq.size(), 0)
    `CHK(u_imcs_tgt.nstop, 1)
    exp = '{8'h55};
    go(mk(1, 10'h02a, 0, AM_7, 1, 3), 0);
    cmp();
    rxchk(3);
    `CHK(u_imcs_tgt.nack, 2)
    `CHK(u_imcs_tgt.nnak, 1)
    exp = '{8'h00, 8'h30};
    go(mk(1, 10'h07f, 0, AM_GC, 1, 1), 1);
    cmp();
    exp = '{8'hf6, 8'hc5, 8'h30};
    go(mk(0, 10'h3c5, 0, AM_10, 1, 1), 1);
    cmp();
    exp = '{8'h01, 8'h22, 8'h30};
    go(mk(0, 10'h011, 1, AM_7, 0, 1), 1);
    cmp();
    `CHK(st[ST_HOLD], 1'b1)
    `CHK(u_imcs_tgt.nstop, 4)
    exp = '{8'hf6, 8'hc5, 8'hf7};
    go(mk(1, 10'h3c5, 0, AM_10, 1, 2), 0);
    cmp();
    rxchk(2);
    `CHK(u_imcs_tgt.nstop, 5)
    summarize();
  end
endmodule // testbench
